// ---- core/uart_flc_consts.svh ----
// Register offsets, field positions, reset values and counts for the frame/loop control block
`ifndef UART_FLC_CONSTS_SVH
`define UART_FLC_CONSTS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define UFC_OFS_CTRL1 3'h0
`define UFC_OFS_CTRL2 3'h1
`define UFC_OFS_CTRL3 3'h2
`define UFC_OFS_DATA 3'h3
`define UFC_OFS_STAT 3'h4
`define UFC_OFS_BAUD 3'h5

// ****************************************
// Control one fields
// ****************************************
`define UFC_C1_LOOP 7
`define UFC_C1_SWAI 6
`define UFC_C1_RECEIVER_SOURCE_SELECT 5
`define UFC_C1_NINE 4
`define UFC_C1_WAKE 3
`define UFC_C1_ILT 2
`define UFC_C1_PEN 1
`define UFC_C1_PODD 0

// ****************************************
// Control two fields
// ****************************************
`define UFC_C2_TIE 7
`define UFC_C2_TX_DONE_IRQ_EN 6
`define UFC_C2_RIE 5
`define UFC_C2_ILIE 4
`define UFC_C2_TE 3
`define UFC_C2_RE 2
`define UFC_C2_RWU 1

// ****************************************
// Control three and status fields
// ****************************************
`define UFC_C3_T8 7
`define UFC_C3_R8 6
`define UFC_C3_DIR 5
`define UFC_ST_TX_BUFFER_EMPTY_FLAG 7
`define UFC_ST_TC 6
`define UFC_ST_RDRF 5
`define UFC_ST_IDLE 4
`define UFC_ST_PERR 0

// ****************************************
// Reset values and counts
// ****************************************
`define UFC_CTRL1_RST 8'h00
`define UFC_CTRL2_RST 8'h00
`define UFC_BAUD_RST 8'h0f
`define UFC_IDLE_BITS8 4'ha
`define UFC_IDLE_BITS9 4'hb
`define UFC_BITS8 4'h8
`define UFC_BITS9 4'h9

`endif

// ---- core/uart_flc_pkg.sv ----
// Types shared by the frame/loop control block
package uart_flc_pkg;
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA = 4'b0100,
    TX_STOP = 4'b1000
  } tx_state_t;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } rx_state_t;
endpackage

// ---- core/uart_tx_buffer.sv ----
// Two-entry valid/ready buffer between the data register and the transmit shifter
module uart_tx_buffer #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys_i, // System clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic in_valid_i, // Word offered
  output logic in_ready_o, // Room for a word
  input wire logic [WIDTH-1:0] in_data_i, // Word in
  output logic out_valid_o, // Word available
  input wire logic out_ready_i, // Drain takes word
  output logic [WIDTH-1:0] out_data_o // Oldest word
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [PW:0] count_ff;
  logic push;
  logic pop;

  // Honest flags straight from the occupancy count
  assign in_ready_o = (count_ff != (PW+1)'(DEPTH));
  assign out_valid_o = (count_ff != '0);
  assign out_data_o = mem_ff[rd_ptr_ff];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage, no reset needed for the data words
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + PW'(1);
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + PW'(1);
      end
      if (push && !pop) begin
        count_ff <= count_ff + (PW+1)'(1);
      end else if (pop && !push) begin
        count_ff <= count_ff - (PW+1)'(1);
      end
    end
  end
endmodule

// ---- core/uart_frame_loop_control.sv ----
// Serial transceiver with loop/single-wire routing, 8/9-bit framing, parity, idle and wakeup control
//
// Operation
// R1 - Loop select routes transmitter into receiver
// R2 - Loop clear: separate receive and transmit pins
// R3 - Receiver source ignored unless loop set
// R4 - Internal loop-back uses neither pin
// R5 - Single-wire: receiver and transmitter share transmit pin
// R6 - Stop-in-wait freezes activity during CPU wait
// R7 - Eight-bit frame: start, LSB-first data, stop
// R8 - Nine-bit frame adds ninth data bit
// R9 - Wake bit picks idle-line or address-mark wakeup
// R10 - Idle type one counts only after stop
// R11 - Idle type zero counts after start bit
// R12 - Parity enable generates and checks MSB parity
// R13 - Parity type: zero even, one odd
// R14 - Transmit-empty enable requests interrupt while empty
// R15 - Complete enable requests interrupt while complete
// R16 - Control two accessible at any time
// R17 - Internal loop-back releases transmit pin driver
// R18 - Single-wire direction bit drives or releases pin
// R19 - Parity mismatch raises parity error flag
`include "uart_flc_consts.svh"

module uart_frame_loop_control import uart_flc_pkg::*; (
  input wire logic clk_sys_i, // 10 MHz system clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic [2:0] addr_i, // Register offset
  input wire logic [7:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [7:0] rdata_o, // Read data, cycle after strobe
  input wire logic cpu_wait_i, // CPU in wait mode
  input wire logic rxd_i, // Receive pin
  input wire logic txd_pin_i, // Transmit pin level as seen
  output logic txd_o, // Transmit pin value
  output logic txd_oe_o, // Transmit pin driver enable
  output logic irq_o // Interrupt request, active high
);
  // ****************************************
  // Registers and decoded fields
  // ****************************************
  logic [7:0] ctrl1_ff;
  logic [7:0] ctrl2_ff;
  logic [7:0] baud_ff;
  logic t8_ff;
  logic dir_ff;
  logic [7:0] rdata_ff;
  logic irq_ff;
  logic oe_ff;
  logic rdrf_ff;
  logic idle_flag_ff;
  logic perr_ff;
  logic [8:0] rx_data_ff;

  logic loop_select, stop_in_wait, receiver_source_select, nine_bit;
  logic wake_mark, idle_count_type, parity_enable, parity_odd_select;
  logic tx_empty_irq_en, tx_done_irq_en, rx_full_irq_en, idle_irq_en;
  logic transmitter_enable, receiver_enable, rx_standby;
  logic tx_buffer_empty_flag, tx_complete_flag;
  logic frz;
  logic [3:0] nbits;
  logic [8:0] bit_len;

  assign loop_select = ctrl1_ff[`UFC_C1_LOOP];
  assign stop_in_wait = ctrl1_ff[`UFC_C1_SWAI];
  assign receiver_source_select = ctrl1_ff[`UFC_C1_RECEIVER_SOURCE_SELECT];
  assign nine_bit = ctrl1_ff[`UFC_C1_NINE];
  assign wake_mark = ctrl1_ff[`UFC_C1_WAKE];
  assign idle_count_type = ctrl1_ff[`UFC_C1_ILT];
  assign parity_enable = ctrl1_ff[`UFC_C1_PEN];
  assign parity_odd_select = ctrl1_ff[`UFC_C1_PODD];
  assign tx_empty_irq_en = ctrl2_ff[`UFC_C2_TIE];
  assign tx_done_irq_en = ctrl2_ff[`UFC_C2_TX_DONE_IRQ_EN];
  assign rx_full_irq_en = ctrl2_ff[`UFC_C2_RIE];
  assign idle_irq_en = ctrl2_ff[`UFC_C2_ILIE];
  assign transmitter_enable = ctrl2_ff[`UFC_C2_TE];
  assign receiver_enable = ctrl2_ff[`UFC_C2_RE];
  assign rx_standby = ctrl2_ff[`UFC_C2_RWU];

  // Frame length and bit time; shortest bit is one cycle
  assign nbits = nine_bit ? `UFC_BITS9 : `UFC_BITS8; // see R7 see R8
  assign bit_len = {1'b0, baud_ff} + 9'h001;
  // Activity holds still, not the clock, so state survives the wait
  assign frz = stop_in_wait && cpu_wait_i; // see R6

  // Odd count of ones over the character, eight or nine bits
  function automatic logic ones_odd(input logic [8:0] d, input logic nine);
    ones_odd = nine ? ^d : ^d[7:0];
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic rxd_s1_ff, rxd_s2_ff, txp_s1_ff, txp_s2_ff;

  // Two stages before any logic reads a pin
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rxd_s1_ff <= 1'b1;
      rxd_s2_ff <= 1'b1;
      txp_s1_ff <= 1'b1;
      txp_s2_ff <= 1'b1;
    end else begin
      rxd_s1_ff <= rxd_i;
      rxd_s2_ff <= rxd_s1_ff;
      txp_s1_ff <= txd_pin_i;
      txp_s2_ff <= txp_s1_ff;
    end
  end

  // ****************************************
  // Transmit buffer and shifter
  // ****************************************
  tx_state_t tx_state_ff;
  logic [8:0] tx_cnt_ff;
  logic [3:0] tx_bit_ff;
  logic [8:0] tx_shift_ff;
  logic tx_line_ff;
  logic buf_push, buf_valid, tx_pop, tx_bit_done;
  logic [8:0] buf_data;
  logic [8:0] nxt_shift;

  assign buf_push = wr_i && (addr_i == `UFC_OFS_DATA);
  assign tx_pop = (tx_state_ff == TX_IDLE) && transmitter_enable && buf_valid && !frz;
  assign tx_bit_done = (tx_cnt_ff == 9'h000);
  // Buffer full backs up into the empty flag; a write while full is dropped
  assign tx_complete_flag = (tx_state_ff == TX_IDLE) && !buf_valid;

  uart_tx_buffer #(
    .WIDTH(9),
    .DEPTH(2)
  ) u_tx_buffer (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(buf_push),
    .in_ready_o(tx_buffer_empty_flag),
    .in_data_i({t8_ff, wdata_i}),
    .out_valid_o(buf_valid),
    .out_ready_i(tx_pop),
    .out_data_o(buf_data)
  );

  // Parity replaces the top data bit of the outgoing character
  always_comb begin
    nxt_shift = buf_data;
    if (parity_enable) begin // see R12
      if (nine_bit) begin
        nxt_shift[8] = ones_odd({1'b0, buf_data[7:0]}, 1'b1) ^ parity_odd_select; // see R13
      end else begin
        nxt_shift[7] = ones_odd({2'b00, buf_data[6:0]}, 1'b0) ^ parity_odd_select; // see R13
      end
    end
  end

  // Frame sequencer: start low, data LSB first, stop high
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_state_ff <= TX_IDLE;
      tx_cnt_ff <= 9'h000;
      tx_bit_ff <= 4'h0;
      tx_shift_ff <= 9'h000;
      tx_line_ff <= 1'b1;
    end else if (tx_pop) begin
      tx_state_ff <= TX_START; // see R7
      tx_shift_ff <= nxt_shift;
      tx_line_ff <= 1'b0;
      tx_cnt_ff <= bit_len - 9'h001;
    end else if (!frz && (tx_state_ff != TX_IDLE)) begin
      if (!tx_bit_done) begin
        tx_cnt_ff <= tx_cnt_ff - 9'h001;
      end else begin
        tx_cnt_ff <= bit_len - 9'h001;
        unique case (tx_state_ff)
          TX_START: begin
            tx_state_ff <= TX_DATA;
            tx_bit_ff <= 4'h0;
            tx_line_ff <= tx_shift_ff[0];
            tx_shift_ff <= tx_shift_ff >> 1;
          end
          TX_DATA: begin
            if (tx_bit_ff == nbits - 4'h1) begin // see R8
              tx_state_ff <= TX_STOP;
              tx_line_ff <= 1'b1;
            end else begin
              tx_bit_ff <= tx_bit_ff + 4'h1;
              tx_line_ff <= tx_shift_ff[0];
              tx_shift_ff <= tx_shift_ff >> 1;
            end
          end
          TX_STOP: begin
            tx_state_ff <= TX_IDLE;
          end
          default: begin
            tx_state_ff <= TX_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Line routing
  // ****************************************
  logic rx_line;

  // Receive source: pin, internal loop, or the shared transmit pin
  assign rx_line = !loop_select ? rxd_s2_ff : // see R2 see R3
                   (receiver_source_select ? txp_s2_ff : tx_line_ff); // see R1 see R4 see R5

  // Pin driver: loop-back frees the pin, single-wire obeys direction
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_ff <= 1'b0;
    end else if (loop_select && !receiver_source_select) begin
      oe_ff <= 1'b0; // see R4 see R17
    end else if (loop_select) begin
      oe_ff <= transmitter_enable && dir_ff; // see R5 see R18
    end else begin
      oe_ff <= transmitter_enable; // see R2
    end
  end

  // ****************************************
  // Receiver
  // ****************************************
  rx_state_t rx_state_ff;
  logic [8:0] rx_cnt_ff;
  logic [3:0] rx_bit_ff;
  logic [8:0] rx_shift_ff;
  logic rx_prev_ff;
  logic rx_done_ff;

  // Mid-bit sampling after a falling edge on the chosen source
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_state_ff <= RX_IDLE;
      rx_cnt_ff <= 9'h000;
      rx_bit_ff <= 4'h0;
      rx_shift_ff <= 9'h000;
      rx_prev_ff <= 1'b1;
      rx_done_ff <= 1'b0;
    end else if (frz) begin
      rx_done_ff <= 1'b0;
    end else begin
      rx_prev_ff <= rx_line;
      rx_done_ff <= 1'b0;
      if (!receiver_enable) begin
        rx_state_ff <= RX_IDLE;
      end else if (rx_state_ff == RX_IDLE) begin
        if (rx_prev_ff && !rx_line) begin
          rx_state_ff <= RX_START;
          rx_cnt_ff <= bit_len >> 1;
        end
      end else if (rx_cnt_ff != 9'h000) begin
        rx_cnt_ff <= rx_cnt_ff - 9'h001;
      end else begin
        rx_cnt_ff <= bit_len - 9'h001;
        unique case (rx_state_ff)
          RX_START: begin
            rx_state_ff <= rx_line ? RX_IDLE : RX_DATA;
            rx_bit_ff <= 4'h0;
            rx_shift_ff <= 9'h000;
          end
          RX_DATA: begin
            rx_shift_ff[rx_bit_ff] <= rx_line; // see R7 see R8
            rx_bit_ff <= rx_bit_ff + 4'h1;
            if (rx_bit_ff == nbits - 4'h1) begin
              rx_state_ff <= RX_STOP;
            end
          end
          RX_STOP: begin
            rx_state_ff <= RX_IDLE;
            rx_done_ff <= rx_line; // Bad stop bit drops the character
          end
          default: begin
            rx_state_ff <= RX_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Idle line detector
  // ****************************************
  logic [8:0] idle_tmr_ff;
  logic [3:0] idle_cnt_ff;
  logic idle_hit_ff;
  logic idle_armed_ff;
  logic idle_en;
  logic [3:0] idle_need;

  // Type one waits for the stop bit; type zero counts from after start
  assign idle_en = idle_count_type ? (rx_state_ff == RX_IDLE) : // see R10
                   (rx_state_ff != RX_START); // see R11
  assign idle_need = nine_bit ? `UFC_IDLE_BITS9 : `UFC_IDLE_BITS8;

  // Any low bit or disabled window restarts the count
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idle_tmr_ff <= 9'h000;
      idle_cnt_ff <= 4'h0;
      idle_hit_ff <= 1'b0;
    end else if (frz) begin
      idle_hit_ff <= 1'b0;
    end else if (!rx_line || !idle_en || !receiver_enable) begin
      idle_tmr_ff <= 9'h000;
      idle_cnt_ff <= 4'h0;
      idle_hit_ff <= 1'b0;
    end else if (idle_cnt_ff == idle_need) begin
      idle_hit_ff <= 1'b0;
    end else if (idle_tmr_ff == bit_len - 9'h001) begin
      idle_tmr_ff <= 9'h000;
      idle_cnt_ff <= idle_cnt_ff + 4'h1;
      idle_hit_ff <= (idle_cnt_ff + 4'h1 == idle_need);
    end else begin
      idle_tmr_ff <= idle_tmr_ff + 9'h001;
      idle_hit_ff <= 1'b0;
    end
  end

  // ****************************************
  // Received character and flags
  // ****************************************
  logic rx_accept, rx_wake_char, rd_data, wr_stat;
  logic [8:0] rx_char;

  assign rx_char = nine_bit ? rx_shift_ff : {1'b0, rx_shift_ff[7:0]};
  assign rx_wake_char = wake_mark && (nine_bit ? rx_shift_ff[8] : rx_shift_ff[7]); // see R9
  assign rx_accept = rx_done_ff && (!rx_standby || rx_wake_char);
  assign rd_data = rd_i && (addr_i == `UFC_OFS_DATA);
  assign wr_stat = wr_i && (addr_i == `UFC_OFS_STAT);

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_data_ff <= 9'h000;
      rdrf_ff <= 1'b0;
      perr_ff <= 1'b0;
      idle_flag_ff <= 1'b0;
      idle_armed_ff <= 1'b0;
    end else begin
      if (rx_accept) begin
        rx_data_ff <= rx_char;
        rdrf_ff <= 1'b1;
      end else if (rd_data) begin
        rdrf_ff <= 1'b0;
      end
      if (rx_accept && parity_enable && (ones_odd(rx_char, nine_bit) != parity_odd_select)) begin
        perr_ff <= 1'b1; // see R13 see R19
      end else if (wr_stat && wdata_i[`UFC_ST_PERR]) begin
        perr_ff <= 1'b0;
      end
      if (idle_hit_ff && idle_armed_ff) begin
        idle_flag_ff <= 1'b1;
      end else if (wr_stat && wdata_i[`UFC_ST_IDLE]) begin
        idle_flag_ff <= 1'b0;
      end
      if (rx_done_ff) begin
        idle_armed_ff <= 1'b1;
      end else if (idle_hit_ff) begin
        idle_armed_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  // Control two has no busy lockout; standby clears on its wake event unless a register write falls in the same cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl1_ff <= `UFC_CTRL1_RST;
      ctrl2_ff <= `UFC_CTRL2_RST;
      baud_ff <= `UFC_BAUD_RST;
      t8_ff <= 1'b0;
      dir_ff <= 1'b0;
    end else if (wr_i) begin
      unique case (addr_i)
        `UFC_OFS_CTRL1: ctrl1_ff <= wdata_i;
        `UFC_OFS_CTRL2: ctrl2_ff <= wdata_i; // see R16
        `UFC_OFS_CTRL3: begin
          t8_ff <= wdata_i[`UFC_C3_T8];
          dir_ff <= wdata_i[`UFC_C3_DIR];
        end
        `UFC_OFS_BAUD: baud_ff <= wdata_i;
        default: ;
      endcase
    end else if ((rx_accept && wake_mark) || (idle_hit_ff && !wake_mark)) begin
      ctrl2_ff[`UFC_C2_RWU] <= 1'b0; // see R9
    end
  end

  // ****************************************
  // Read data and interrupt
  // ****************************************
  // Read data stands for exactly one cycle, zero otherwise
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 8'h00;
    end else if (!rd_i) begin
      rdata_ff <= 8'h00;
    end else begin
      unique case (addr_i)
        `UFC_OFS_CTRL1: rdata_ff <= ctrl1_ff;
        `UFC_OFS_CTRL2: rdata_ff <= ctrl2_ff; // see R16
        `UFC_OFS_CTRL3: rdata_ff <= {t8_ff, rx_data_ff[8], dir_ff, 5'h00};
        `UFC_OFS_DATA: rdata_ff <= rx_data_ff[7:0];
        `UFC_OFS_STAT: rdata_ff <= {tx_buffer_empty_flag, tx_complete_flag, rdrf_ff, idle_flag_ff, 3'h0, perr_ff};
        `UFC_OFS_BAUD: rdata_ff <= baud_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  // Level request while any enabled flag stands
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (tx_empty_irq_en && tx_buffer_empty_flag) || // see R14
                (tx_done_irq_en && tx_complete_flag) || // see R15
                (rx_full_irq_en && rdrf_ff) || (idle_irq_en && idle_flag_ff);
    end
  end

  assign rdata_o = rdata_ff;
  assign irq_o = irq_ff;
  assign txd_o = tx_line_ff;
  assign txd_oe_o = oe_ff;

  // ****************************************
  // Assertions
  // ****************************************
  sequence tx_launch_s;
    tx_pop ##1 (tx_state_ff == TX_START && !tx_line_ff);
  endsequence

  property parity_out_p;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (tx_pop && parity_enable && !frz) |=> (ones_odd(tx_shift_ff, nine_bit) == parity_odd_select);
  endproperty

  loop_pin_free_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R17
    $past(loop_select) && !$past(receiver_source_select) |-> !txd_oe_o)
    else $error("pin driven in internal loop-back");
  normal_pin_drive_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R2
    !$past(loop_select) |-> (txd_oe_o == $past(transmitter_enable)))
    else $error("pin driver wrong in normal mode");
  wire_direction_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R18
    $past(loop_select) && $past(receiver_source_select) |-> (txd_oe_o == ($past(dir_ff) && $past(transmitter_enable))))
    else $error("single-wire direction ignored");
  frame_start_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R7
    tx_pop |-> tx_launch_s)
    else $error("start bit not low");
  data_count_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R8
    (tx_state_ff == TX_STOP) |-> (tx_line_ff && tx_bit_ff == nbits - 4'h1))
    else $error("wrong data bit count");
  parity_out_a: assert property (parity_out_p) // see R13
    else $error("outgoing parity wrong");
  wait_freeze_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R6
    frz && (tx_state_ff != TX_IDLE) |=> $stable(tx_cnt_ff) && $stable(tx_line_ff))
    else $error("transmitter moved while frozen");
  empty_irq_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R14
    tx_empty_irq_en && tx_buffer_empty_flag |=> irq_o)
    else $error("missing transmit-empty interrupt");
  done_irq_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R15
    tx_done_irq_en && tx_complete_flag |=> irq_o)
    else $error("missing complete interrupt");
  ctrl2_read_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R16
    rd_i && (addr_i == `UFC_OFS_CTRL2) |=> (rdata_o == $past(ctrl2_ff)))
    else $error("control two read wrong");
  idle_late_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see R10
    idle_count_type && (rx_state_ff != RX_IDLE) |=> (idle_cnt_ff == 4'h0))
    else $error("idle counted inside character");
endmodule

// ---- verif/serial_node.sv ----
// Behavioural remote serial node on the transmit and receive lines
module serial_node #(
  parameter int BL = 4
) (
  input wire logic clk_i, // Bench clock
  input wire logic line_i, // Line from block
  input wire logic [3:0] nbits_i, // Data bits a frame
  output logic ser_o, // Line to block
  output logic [8:0] got_o, // Last word seen
  output int frames_o // Frames with good stop
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ser_o = 1'b1;
    frames_o = 0;
  end
  // Mid-cell sampling, LSB first; a low stop cell is not counted
  always begin
    @(negedge line_i);
    got_o = '0;
    repeat (BL / 2) @(posedge clk_i);
    for (int i = 0; i < nbits_i; i++) begin
      repeat (BL) @(posedge clk_i);
      got_o[i] = line_i;
    end
    repeat (BL) @(posedge clk_i);
    if (line_i) frames_o++;
  end
  // Frame out; line idles high after the stop cell
  task automatic send(input logic [8:0] w);
    ser_o <= 1'b0;
    for (int i = 0; i <= nbits_i; i++) begin
      repeat (BL) @(posedge clk_i);
      ser_o <= (i == nbits_i) ? 1'b1 : w[i];
    end
    repeat (BL + 1) @(posedge clk_i);
  endtask
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the frame and loop control block
`include "uart_flc_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, cpu_wait_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00, rdata_o, rv;
  logic txd_o, txd_oe_o, irq_o, ser_w;
  logic [8:0] got, w;
  logic [3:0] nbits = 4'h8;
  logic [31:0] seed = 32'h000140d9;
  int err_total = 0, checks_done = 0, frames, n0;
  // Peer drives the shared pin only while the block releases it
  wire logic pin_w = txd_oe_o ? txd_o : ser_w;
  `define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; $display("unexpected at %0t got %h exp %h", $time, g, e); end end
  always #50 clk_sys_i = ~clk_sys_i;
  uart_frame_loop_control dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cpu_wait_i(cpu_wait_i), .rxd_i(ser_w), .txd_pin_i(pin_w),
    .txd_o(txd_o), .txd_oe_o(txd_oe_o), .irq_o(irq_o));
  serial_node #(.BL(4)) peer (.clk_i(clk_sys_i), .line_i(pin_w), .nbits_i(nbits), .ser_o(ser_w), .got_o(got),
    .frames_o(frames));
  // ****************************************
  // Bus tasks and expectations
  // ****************************************
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask
  // Stale read data must not end the poll early; a poll that runs out is a mismatch
  task automatic wait_rx();
    rv = 8'h00;
    for (int k = 0; k < 40 && !rv[`UFC_ST_RDRF]; k++) rd(`UFC_OFS_STAT);
    if (!rv[`UFC_ST_RDRF]) err_total++;
  endtask
  // One extra cell lets the stop bit finish before the next change
  task automatic wait_frame();
    for (int k = 0; k < 300 && frames == n0; k++) @(posedge clk_sys_i);
    if (frames == n0) err_total++;
    repeat (4) @(posedge clk_sys_i);
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Top data bit replaced by parity over the rest
  function automatic logic [8:0] exp_tx(input logic [8:0] d, input logic [2:0] m);
    exp_tx = m[2] ? d : {1'b0, d[7:0]};
    if (m[1] && m[2]) exp_tx[8] = ^d[7:0] ^ m[0];
    else if (m[1]) exp_tx[7] = ^d[6:0] ^ m[0];
  endfunction
  task automatic finish_test();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd(`UFC_OFS_CTRL1);
    `CHK(rv, `UFC_CTRL1_RST)
    rd(`UFC_OFS_CTRL2);
    `CHK(rv, `UFC_CTRL2_RST)
    wr(`UFC_OFS_BAUD, 8'h03);
    wr(`UFC_OFS_CTRL1, 8'h20);
    wr(`UFC_OFS_CTRL2, 8'h0c);
    rd(`UFC_OFS_STAT);
    `CHK(txd_oe_o, 1'b1)
    for (int m = 0; m < 8; m++) begin
      seed = lfsr(seed);
      w = seed[8:0];
      nbits <= m[2] ? 4'h9 : 4'h8;
      wr(`UFC_OFS_CTRL1, {3'h0, m[2], 2'h0, m[1:0]});
      wr(`UFC_OFS_CTRL3, {w[8], 7'h00});
      n0 = frames;
      wr(`UFC_OFS_DATA, w[7:0]);
      wait_frame();
      `CHK(got, exp_tx(w, m[2:0]))
    end
    $display("test framing done");
    nbits <= 4'h8;
    wr(`UFC_OFS_CTRL1, 8'h02);
    seed = lfsr(seed);
    peer.send({1'b0, seed[7:0]});
    wait_rx();
    rd(`UFC_OFS_DATA);
    `CHK(rv, seed[7:0])
    rd(`UFC_OFS_STAT);
    `CHK(rv[`UFC_ST_PERR], ^seed[7:0])
    $display("test receive done");
    wr(`UFC_OFS_CTRL2, 8'h88);
    rd(`UFC_OFS_CTRL2);
    `CHK(irq_o, 1'b1)
    wr(`UFC_OFS_CTRL2, 8'h48);
    n0 = frames;
    wr(`UFC_OFS_DATA, 8'ha5);
    rd(`UFC_OFS_CTRL2);
    `CHK(irq_o, 1'b0)
    `CHK(rv, 8'h48)
    wait_frame();
    rd(`UFC_OFS_CTRL2);
    `CHK(irq_o, 1'b1)
    $display("test interrupt done");
    wr(`UFC_OFS_CTRL2, 8'h0c);
    wr(`UFC_OFS_CTRL1, 8'h40);
    cpu_wait_i <= 1'b1;
    n0 = frames;
    wr(`UFC_OFS_DATA, 8'h3c);
    repeat (60) @(posedge clk_sys_i);
    `CHK(frames, n0)
    cpu_wait_i <= 1'b0;
    wait_frame();
    `CHK(got, 9'h03c)
    $display("test wait done");
    wr(`UFC_OFS_CTRL1, 8'h80);
    n0 = frames;
    wr(`UFC_OFS_DATA, 8'h96);
    wait_rx();
    `CHK(txd_oe_o, 1'b0)
    `CHK(frames, n0)
    rd(`UFC_OFS_DATA);
    `CHK(rv, 8'h96)
    wr(`UFC_OFS_CTRL1, 8'ha0);
    wr(`UFC_OFS_CTRL3, 8'h20);
    rd(`UFC_OFS_CTRL3);
    `CHK(txd_oe_o, 1'b1)
    wr(`UFC_OFS_CTRL3, 8'h00);
    // Driver lets go of the shared pin one edge later; a start cut short would shift every sample
    @(posedge clk_sys_i);
    peer.send(9'h05a);
    wait_rx();
    `CHK(txd_oe_o, 1'b0)
    wr(`UFC_OFS_STAT, 8'h10);
    rd(`UFC_OFS_DATA);
    `CHK(rv, 8'h5a)
    wr(`UFC_OFS_CTRL2, 8'h0e);
    repeat (60) @(posedge clk_sys_i);
    rd(`UFC_OFS_CTRL2);
    `CHK(rv, 8'h0c)
    rd(`UFC_OFS_STAT);
    `CHK(rv[`UFC_ST_IDLE], 1'b1)
    $display("test loop done");
    finish_test();
  end
  // Whole run needs well under this many cycles
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    err_total++;
    finish_test();
  end
endmodule
